// ---- design/cpu_port_pkg.sv ----
// Constants shared by the CPU-side port logic and its posting buffer.
// Assumes a 16-bit register port and one 200 MHz clock.
package cpu_port_pkg;

  localparam int unsigned REG_AW = 16;
  localparam int unsigned REG_DW = 16;

  // Register offsets on the register port
  localparam logic [15:0] PERIPH_PORT_CONFIG_OFS = 16'h0100;
  localparam logic [15:0] PERIPH_PORT_ERROR_OFS  = 16'h0102;
  localparam logic [15:0] MEM_PORT_CONFIG_OFS    = 16'h0200;
  localparam logic [15:0] MEM_PORT_ERROR_OFS     = 16'h0202;
  localparam logic [15:0] IRQ_STATUS_OFS         = 16'h0310;
  localparam logic [15:0] IRQ_MASK_OFS           = 16'h0312;

  // Field positions
  localparam int unsigned BUS_ERROR_ENABLE_BIT   = 15;
  localparam int unsigned INTERNAL_BUS_ERR_BIT   = 15;
  localparam int unsigned PERIPH_TIMEOUT_BIT     = 12;
  localparam int unsigned WRITE_PATH_ERR_BIT     = 4;
  localparam int unsigned READ_PATH_ERR_BIT      = 3;
  localparam int unsigned POSTING_ENABLE_BIT     = 7;
  localparam int unsigned EXT_MEM_TIMEOUT_BIT    = 12;

  // Reset values
  localparam logic BUS_ERROR_ENABLE_RST = 1'b1;
  localparam logic POSTING_ENABLE_RST   = 1'b0;

  // Interrupt status and mask layout
  localparam int unsigned IRQ_W            = 4;
  localparam int unsigned IRQ_BUS_ERR      = 0;
  localparam int unsigned IRQ_PER_TIMEOUT  = 1;
  localparam int unsigned IRQ_XMEM_TIMEOUT = 2;
  localparam int unsigned IRQ_IDLE_ERR     = 3;

  // Cycles without answer before an access is declared timed out
  localparam int unsigned TIMEOUT_COUNT = 512;
  localparam int unsigned POST_DEPTH    = 2;

  // Address ranges checked for invalid accesses
  localparam logic [15:0] SCOPE0_LO = 16'h0000;
  localparam logic [15:0] SCOPE0_HI = 16'h03FF;
  localparam logic [15:0] SCOPE1_LO = 16'h1400;
  localparam logic [15:0] SCOPE1_HI = 16'h17FF;
  localparam logic [15:0] SCOPE2_LO = 16'h2000;
  localparam logic [15:0] SCOPE2_HI = 16'h23FF;

endpackage

// ---- design/posting_buffer.sv ----
// Write-posting store: a small queue of address and data words.
// Assumes the owner never pushes when full nor pops when empty.
`timescale 1ns/1ps
module posting_buffer #(
  parameter int unsigned WIDTH = 56,
  parameter int unsigned DEPTH = 2,
  parameter int unsigned LVL_W = $clog2(DEPTH + 1)
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             push_i,
  input  wire logic [WIDTH-1:0] push_data_i,
  input  wire logic             pop_i,
  output logic      [WIDTH-1:0] head_data_o,
  output logic                  valid_o,
  output logic      [LVL_W-1:0] level_o
);

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [LVL_W-1:0] next_level;

  function automatic logic [PTR_W-1:0] advance(input logic [PTR_W-1:0] p);
    advance = (p == LAST) ? '0 : p + PTR_W'(1);
  endfunction

  always_comb
  begin
    next_level = level_o;
    if (push_i && !pop_i)
    begin
      next_level = level_o + LVL_W'(1);
    end
    else if (pop_i && !push_i)
    begin
      next_level = level_o - LVL_W'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (push_i)
    begin
      store[wr_ptr] <= push_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      level_o <= '0;
      valid_o <= 1'b0;
    end
    else
    begin
      if (push_i)
      begin
        wr_ptr <= advance(wr_ptr);
      end
      if (pop_i)
      begin
        rd_ptr <= advance(rd_ptr);
      end
      level_o <= next_level;
      valid_o <= (next_level != '0);
    end
  end

  assign head_data_o = store[rd_ptr];

endmodule

// ---- design/cpu_port_bridge.sv ----
// CPU-side peripheral port checker and external memory write port.
// Assumes one clock, a synchronous reset and single-cycle register strobes.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module cpu_port_bridge
  import cpu_port_pkg::*;
#(
  parameter int unsigned XADDR_W        = 24,
  parameter int unsigned XDATA_W        = 32,
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_COUNT
) (
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  input  wire logic [REG_AW-1:0]  reg_addr_i,
  input  wire logic [REG_DW-1:0]  reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output logic      [REG_DW-1:0]  reg_rdata_o,
  input  wire logic               per_req_i,
  input  wire logic               per_write_i,
  input  wire logic [15:0]        per_addr_i,
  input  wire logic               per_invalid_i,
  input  wire logic               per_ack_i,
  output logic                    per_stall_o,
  output logic                    per_done_o,
  output logic                    per_bus_error_o,
  input  wire logic               idle_instr_i,
  input  wire logic               wake_i,
  input  wire logic               periph_idle_request_i,
  input  wire logic               ext_mem_idle_request_i,
  input  wire logic               cpu_idle_i,
  input  wire logic               master_idle_i,
  input  wire logic               peripheral_timeout_enable_i,
  input  wire logic               ext_mem_timeout_enable_i,
  output logic                    periph_idle_o,
  output logic                    mem_idle_o,
  output logic                    idle_bus_error_o,
  input  wire logic               mem_wr_req_i,
  input  wire logic [XADDR_W-1:0] mem_wr_addr_i,
  input  wire logic [XDATA_W-1:0] mem_wr_data_i,
  output logic                    mem_wr_stall_o,
  output logic                    xmem_req_o,
  output logic      [XADDR_W-1:0] xmem_addr_o,
  output logic      [XDATA_W-1:0] xmem_data_o,
  input  wire logic               xmem_ack_i,
  input  wire logic               xmem_other_wait_i,
  output logic                    irq_o
);

  localparam int unsigned LVL_W = $clog2(POST_DEPTH + 1);
  localparam int unsigned CNT_W = $clog2(TIMEOUT_CYCLES);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_CYCLES - 1);
  localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(POST_DEPTH);

  typedef enum logic [3:0] {
    P_READY = 4'b0001,
    P_BUSY  = 4'b0010,
    P_HANG  = 4'b0100,
    P_OFF   = 4'b1000
  } per_state_t;

  per_state_t       per_state;
  per_state_t       next_per_state;
  logic             bus_error_enable;
  logic             posting_enable;
  logic             internal_bus_error_flag;
  logic             peripheral_timeout_flag;
  logic             write_path_error_flag;
  logic             read_path_error_flag;
  logic             ext_mem_timeout_flag;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_event;
  logic [CNT_W-1:0] per_cnt;
  logic [CNT_W-1:0] xmem_cnt;
  logic             invalid_hit;
  logic             berr_evt;
  logic             per_tmo_evt;
  logic             xmem_wait;
  logic             xmem_tmo_evt;
  logic             periph_idle_enter;
  logic             mem_idle_enter;
  logic             idle_err_evt;
  logic             push;
  logic             pop;
  logic             buf_valid;
  logic [LVL_W-1:0] level;
  logic [LVL_W-1:0] next_level;
  logic [REG_DW-1:0] next_rdata;
  logic [XADDR_W+XDATA_W-1:0] head;

  function automatic logic in_scope(input logic [15:0] a);
    in_scope = (a >= SCOPE0_LO && a <= SCOPE0_HI) ||
               (a >= SCOPE1_LO && a <= SCOPE1_HI) ||
               (a >= SCOPE2_LO && a <= SCOPE2_HI);
  endfunction

  function automatic logic reg_hit(input logic [15:0] ofs);
    reg_hit = (reg_addr_i == ofs);
  endfunction

  // Peripheral port access checking
  assign invalid_hit = per_req_i && per_invalid_i && in_scope(per_addr_i);
  assign berr_evt    = (per_state == P_READY) && !periph_idle_o &&
                       invalid_hit && bus_error_enable;
  assign per_tmo_evt = (per_state == P_BUSY) && !per_ack_i &&
                       peripheral_timeout_enable_i && (per_cnt == CNT_LAST);

  always_comb
  begin
    next_per_state = per_state;
    case (per_state)
      P_READY:
      begin
        if (periph_idle_o)
        begin
          next_per_state = P_OFF;
        end
        else if (invalid_hit && !bus_error_enable)
        begin
          next_per_state = P_HANG;
        end
        else if (per_req_i && !invalid_hit && !per_ack_i)
        begin
          next_per_state = P_BUSY;
        end
      end
      P_BUSY:
      begin
        if (per_ack_i || per_tmo_evt)
        begin
          next_per_state = P_READY;
        end
      end
      P_HANG:  next_per_state = P_HANG;
      P_OFF:
      begin
        if (!periph_idle_o)
        begin
          next_per_state = P_READY;
        end
      end
      default: next_per_state = P_READY;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      per_state       <= P_READY;
      per_stall_o     <= 1'b0;
      per_done_o      <= 1'b0;
      per_bus_error_o <= 1'b0;
    end
    else
    begin
      per_state       <= next_per_state;
      per_stall_o     <= (next_per_state != P_READY);
      per_done_o      <= ((per_state == P_READY) && !periph_idle_o &&
                          per_req_i && (per_ack_i || berr_evt)) ||
                         ((per_state == P_BUSY) && (per_ack_i || per_tmo_evt));
      per_bus_error_o <= berr_evt || per_tmo_evt;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i || per_state != P_BUSY)
    begin
      per_cnt <= '0;
    end
    else
    begin
      per_cnt <= per_cnt + CNT_W'(1);
    end
  end

  // Error flags are sticky until reset
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      internal_bus_error_flag <= 1'b0;
      peripheral_timeout_flag <= 1'b0;
      write_path_error_flag   <= 1'b0;
      read_path_error_flag    <= 1'b0;
      ext_mem_timeout_flag    <= 1'b0;
    end
    else
    begin
      if (berr_evt)
      begin
        internal_bus_error_flag <= 1'b1;
      end
      if (per_tmo_evt)
      begin
        peripheral_timeout_flag <= 1'b1;
      end
      if (berr_evt && per_write_i)
      begin
        write_path_error_flag <= 1'b1;
      end
      if (berr_evt && !per_write_i)
      begin
        read_path_error_flag <= 1'b1;
      end
      if (xmem_tmo_evt)
      begin
        ext_mem_timeout_flag <= 1'b1;
      end
    end
  end

  // Idle control of both ports
  assign periph_idle_enter = idle_instr_i && periph_idle_request_i &&
                             !periph_idle_o;
  assign mem_idle_enter    = idle_instr_i && ext_mem_idle_request_i &&
                             !mem_idle_o;
  assign idle_err_evt = (periph_idle_enter && !cpu_idle_i) ||
                        (mem_idle_enter && !cpu_idle_i && !master_idle_i);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      periph_idle_o    <= 1'b0;
      mem_idle_o       <= 1'b0;
      idle_bus_error_o <= 1'b0;
    end
    else
    begin
      if (periph_idle_enter)
      begin
        periph_idle_o <= 1'b1;
      end
      else if (wake_i)
      begin
        periph_idle_o <= 1'b0;
      end
      if (mem_idle_enter)
      begin
        mem_idle_o <= 1'b1;
      end
      else if (wake_i)
      begin
        mem_idle_o <= 1'b0;
      end
      idle_bus_error_o <= idle_err_evt;
    end
  end

  // Memory port write posting
  assign push = mem_wr_req_i && !mem_wr_stall_o && !mem_idle_o;
  assign pop  = buf_valid && xmem_ack_i && !mem_idle_o;

  always_comb
  begin
    next_level = level;
    if (push && !pop)
    begin
      next_level = level + LVL_W'(1);
    end
    else if (pop && !push)
    begin
      next_level = level - LVL_W'(1);
    end
  end

  posting_buffer #(
    .WIDTH (XADDR_W + XDATA_W),
    .DEPTH (POST_DEPTH),
    .LVL_W (LVL_W)
  ) u_post (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .push_i      (push),
    .push_data_i ({mem_wr_addr_i, mem_wr_data_i}),
    .pop_i       (pop),
    .head_data_o (head),
    .valid_o     (buf_valid),
    .level_o     (level)
  );

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      mem_wr_stall_o <= 1'b0;
      xmem_req_o     <= 1'b0;
    end
    else
    begin
      if (mem_idle_o || mem_idle_enter)
      begin
        mem_wr_stall_o <= 1'b1;
      end
      else if (posting_enable)
      begin
        mem_wr_stall_o <= (next_level == LVL_FULL);
      end
      else
      begin
        mem_wr_stall_o <= (next_level != '0);
      end
      xmem_req_o <= (next_level != '0) && !mem_idle_o && !mem_idle_enter;
    end
  end

  assign xmem_addr_o = head[XADDR_W+XDATA_W-1:XDATA_W];
  assign xmem_data_o = head[XDATA_W-1:0];

  // External memory time-out watch
  assign xmem_wait    = (buf_valid && !xmem_ack_i) || xmem_other_wait_i;
  assign xmem_tmo_evt = ext_mem_timeout_enable_i && xmem_wait &&
                        (xmem_cnt == CNT_LAST);

  always_ff @(posedge clk_i)
  begin
    if (reset_i || !xmem_wait || xmem_tmo_evt)
    begin
      xmem_cnt <= '0;
    end
    else
    begin
      xmem_cnt <= xmem_cnt + CNT_W'(1);
    end
  end

  // Register port
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      bus_error_enable <= BUS_ERROR_ENABLE_RST;
      posting_enable   <= POSTING_ENABLE_RST;
      irq_mask         <= '0;
    end
    else if (reg_wr_i)
    begin
      if (reg_hit(PERIPH_PORT_CONFIG_OFS))
      begin
        bus_error_enable <= reg_wdata_i[BUS_ERROR_ENABLE_BIT];
      end
      if (reg_hit(MEM_PORT_CONFIG_OFS))
      begin
        posting_enable <= reg_wdata_i[POSTING_ENABLE_BIT];
      end
      if (reg_hit(IRQ_MASK_OFS))
      begin
        irq_mask <= reg_wdata_i[IRQ_W-1:0];
      end
    end
  end

  always_comb
  begin
    irq_event = '0;
    irq_event[IRQ_BUS_ERR]      = berr_evt;
    irq_event[IRQ_PER_TIMEOUT]  = per_tmo_evt;
    irq_event[IRQ_XMEM_TIMEOUT] = xmem_tmo_evt;
    irq_event[IRQ_IDLE_ERR]     = idle_err_evt;
  end

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      irq_status <= '0;
      irq_o      <= 1'b0;
    end
    else
    begin
      if (reg_wr_i && reg_hit(IRQ_STATUS_OFS))
      begin
        irq_status <= (irq_status & ~reg_wdata_i[IRQ_W-1:0]) | irq_event;
      end
      else
      begin
        irq_status <= irq_status | irq_event;
      end
      irq_o <= |((irq_status | irq_event) & irq_mask &
                 ~((reg_wr_i && reg_hit(IRQ_STATUS_OFS)) ?
                   reg_wdata_i[IRQ_W-1:0] & ~irq_event : '0));
    end
  end

  always_comb
  begin
    next_rdata = '0;
    case (1'b1)
      reg_hit(PERIPH_PORT_CONFIG_OFS):
        next_rdata[BUS_ERROR_ENABLE_BIT] = bus_error_enable;
      reg_hit(PERIPH_PORT_ERROR_OFS):
      begin
        next_rdata[INTERNAL_BUS_ERR_BIT] = internal_bus_error_flag;
        next_rdata[PERIPH_TIMEOUT_BIT]   = peripheral_timeout_flag;
        next_rdata[WRITE_PATH_ERR_BIT]   = write_path_error_flag;
        next_rdata[READ_PATH_ERR_BIT]    = read_path_error_flag;
      end
      reg_hit(MEM_PORT_CONFIG_OFS):
        next_rdata[POSTING_ENABLE_BIT] = posting_enable;
      reg_hit(MEM_PORT_ERROR_OFS):
        next_rdata[EXT_MEM_TIMEOUT_BIT] = ext_mem_timeout_flag;
      reg_hit(IRQ_STATUS_OFS):
        next_rdata[IRQ_W-1:0] = irq_status;
      reg_hit(IRQ_MASK_OFS):
        next_rdata[IRQ_W-1:0] = irq_mask;
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      reg_rdata_o <= '0;
    end
    else
    begin
      reg_rdata_o <= reg_rd_i ? next_rdata : '0;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_invalid_in_ready;
    per_state == P_READY && !periph_idle_o && invalid_hit;
  endsequence

  a_berr_raised: assert property (
    s_invalid_in_ready ##0 bus_error_enable |=> per_bus_error_o && per_done_o)
    else $error("bus error not raised on invalid access");
  a_hang_silent: assert property (
    s_invalid_in_ready ##0 !bus_error_enable |=>
      per_state == P_HANG && !per_bus_error_o ##1 per_stall_o [*3])
    else $error("invalid access with checking off did not hang");
  a_int_flag: assert property (
    berr_evt |=> internal_bus_error_flag)
    else $error("internal bus error flag not set");
  a_wr_rd_flags: assert property (
    berr_evt |=> (per_write_i ? write_path_error_flag : read_path_error_flag))
    else $error("write or read error flag not set");
  a_idle_no_check: assert property (
    periph_idle_o && per_state == P_OFF |=> !per_bus_error_o)
    else $error("bus error raised while peripheral port idled");
  a_per_timeout: assert property (
    per_state == P_BUSY && per_cnt == CNT_LAST && !per_ack_i &&
    peripheral_timeout_enable_i |=> peripheral_timeout_flag && per_done_o)
    else $error("peripheral time-out missed at 512 cycles");
  a_flags_sticky: assert property (
    internal_bus_error_flag && ext_mem_timeout_flag |=>
      internal_bus_error_flag && ext_mem_timeout_flag)
    else $error("error flag dropped without reset");
  a_post_stall: assert property (
    mem_wr_stall_o && $past(posting_enable) && !$past(mem_idle_o) &&
    !$past(mem_idle_enter) |-> level == LVL_FULL)
    else $error("posting stall while a buffer is free");
  a_post_off: assert property (
    !posting_enable && !$past(posting_enable) && $past(level) <= 1 |->
      level <= 1)
    else $error("write posted with posting disabled");
  a_xmem_timeout: assert property (
    xmem_wait && xmem_cnt == CNT_LAST |=>
      ext_mem_timeout_flag == ($past(ext_mem_timeout_flag) ||
                               $past(ext_mem_timeout_enable_i)))
    else $error("external time-out flag wrong");
  a_mem_idle_gate: assert property (
    mem_idle_o |-> !push && !pop ##1 !xmem_req_o || !mem_idle_o)
    else $error("idled memory port moved a request");
  a_idle_berr: assert property (
    mem_idle_enter && !cpu_idle_i && !master_idle_i |=> idle_bus_error_o)
    else $error("premature memory idle did not raise bus error");

endmodule

// ---- test/far_side_model.sv ----
// Behavioural far side: peripheral registers and external memory interface.
// Assumes the bench sets each wait; 8'hFF means the side never answers.
`timescale 1ns/1ps
module far_side_model (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       per_busy_i,
  input  wire logic       xmem_req_i,
  input  wire logic [7:0] per_wait_i,
  input  wire logic [7:0] xmem_wait_i,
  output logic            per_ack_o,
  output logic            xmem_ack_o
);
  logic [7:0] per_cnt;
  logic [7:0] xmem_cnt;

  // One ack pulse per access, after the chosen number of busy cycles
  always_ff @(posedge clk_i)
  begin
    per_ack_o <= !reset_i && per_busy_i && !per_ack_o
                 && per_wait_i != 8'hFF && per_cnt >= per_wait_i;
    per_cnt   <= (reset_i || !per_busy_i || per_ack_o) ? 8'h00
                 : per_cnt + 8'h01;
  end

  // Takes one posted entry per ack, with a gap cycle between entries
  always_ff @(posedge clk_i)
  begin
    xmem_ack_o <= !reset_i && xmem_req_i && !xmem_ack_o
                  && xmem_wait_i != 8'hFF && xmem_cnt >= xmem_wait_i;
    xmem_cnt   <= (reset_i || !xmem_req_i || xmem_ack_o) ? 8'h00
                  : xmem_cnt + 8'h01;
  end
endmodule

// ---- test/cpu_port_bridge_bench.sv ----
// Self-checking bench for the CPU port bridge with its far side model.
// Assumes a short time-out parameter of 8 cycles and one 200 MHz clock.
`timescale 1ns/1ps
module cpu_port_bridge_bench;
  import cpu_port_pkg::*;
  logic clk_i = 0, reset_i = 1, reg_wr_i = 0, reg_rd_i = 0, per_req_i = 0;
  logic per_write_i = 0, per_invalid_i = 0, idle_instr_i = 0, wake_i = 0;
  logic periph_idle_request_i = 0, ext_mem_idle_request_i = 0;
  logic cpu_idle_i = 0, master_idle_i = 0, mem_wr_req_i = 0;
  logic xmem_other_wait = 0;
  logic peripheral_timeout_enable_i = 0, ext_mem_timeout_enable_i = 0;
  logic [15:0] reg_addr_i = 0, reg_wdata_i = 0, per_addr_i = 0;
  logic [15:0] reg_rdata_o;
  logic [23:0] mem_wr_addr_i = 0, xmem_addr_o;
  logic [31:0] mem_wr_data_i = 0, xmem_data_o;
  logic [7:0]  per_wait = 8'h02, xmem_wait = 8'h00;
  logic per_ack_i, per_stall_o, per_done_o, per_bus_error_o, periph_idle_o;
  logic mem_idle_o, idle_bus_error_o, mem_wr_stall_o, xmem_req_o;
  logic xmem_ack_i, irq_o, irq_a;
  int n_mismatch = 0, n_tests = 0, cyc = 0;

  cpu_port_bridge #(.TIMEOUT_CYCLES(8)) DUT (.clk_i(clk_i), .reset_i(reset_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .per_req_i(per_req_i),
    .per_write_i(per_write_i), .per_addr_i(per_addr_i),
    .per_invalid_i(per_invalid_i), .per_ack_i(per_ack_i),
    .per_stall_o(per_stall_o), .per_done_o(per_done_o),
    .per_bus_error_o(per_bus_error_o), .idle_instr_i(idle_instr_i),
    .wake_i(wake_i), .periph_idle_request_i(periph_idle_request_i),
    .ext_mem_idle_request_i(ext_mem_idle_request_i), .cpu_idle_i(cpu_idle_i),
    .master_idle_i(master_idle_i),
    .peripheral_timeout_enable_i(peripheral_timeout_enable_i),
    .ext_mem_timeout_enable_i(ext_mem_timeout_enable_i),
    .periph_idle_o(periph_idle_o), .mem_idle_o(mem_idle_o),
    .idle_bus_error_o(idle_bus_error_o), .mem_wr_req_i(mem_wr_req_i),
    .mem_wr_addr_i(mem_wr_addr_i), .mem_wr_data_i(mem_wr_data_i),
    .mem_wr_stall_o(mem_wr_stall_o), .xmem_req_o(xmem_req_o),
    .xmem_addr_o(xmem_addr_o), .xmem_data_o(xmem_data_o),
    .xmem_ack_i(xmem_ack_i), .xmem_other_wait_i(xmem_other_wait),
    .irq_o(irq_o));

  far_side_model far (.clk_i(clk_i), .reset_i(reset_i),
    .per_busy_i(per_stall_o), .xmem_req_i(xmem_req_o),
    .per_wait_i(per_wait), .xmem_wait_i(xmem_wait),
    .per_ack_o(per_ack_i), .xmem_ack_o(xmem_ack_i));

  always #2.5 clk_i = ~clk_i;

  task automatic final_report();
    if (n_mismatch == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Cuts a hang short
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic do_reset();
    reset_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, exp);
  endtask

  // One peripheral access; waits for completion and checks the error pulse
  task automatic acc(input logic w, input logic [15:0] a, input logic inv,
                     input logic exp_err);
    int n;
    @(posedge clk_i);
    per_req_i <= 1'b1;
    per_write_i <= w;
    per_addr_i <= a;
    per_invalid_i <= inv;
    @(posedge clk_i);
    per_req_i <= 1'b0;
    n = 0;
    #1;
    while (per_done_o !== 1'b1 && n < 40)
    begin
      @(posedge clk_i);
      #1 n++;
    end
    chk(per_done_o, 1'b1);
    chk(per_bus_error_o, exp_err);
  endtask

  task automatic t_reset_values();
    rd(PERIPH_PORT_CONFIG_OFS, 16'h8000);
    rd(PERIPH_PORT_ERROR_OFS, 16'h0000);
    rd(MEM_PORT_CONFIG_OFS, 16'h0000);
    rd(16'h0400, 16'h0000);
    wr(PERIPH_PORT_ERROR_OFS, 16'hFFFF);
    rd(PERIPH_PORT_ERROR_OFS, 16'h0000);
  endtask

  task automatic t_periph();
    peripheral_timeout_enable_i <= 1'b1;
    acc(1'b0, 16'h0800, 1'b0, 1'b0);
    per_wait <= 8'hFF;
    acc(1'b0, 16'h0800, 1'b0, 1'b1);
    rd(PERIPH_PORT_ERROR_OFS, 16'h1000);
    acc(1'b1, 16'h1400, 1'b1, 1'b1);
    rd(PERIPH_PORT_ERROR_OFS, 16'h9010);
    acc(1'b0, 16'h23FF, 1'b1, 1'b1);
    rd(PERIPH_PORT_ERROR_OFS, 16'h9018);
    per_wait <= 8'h02;
  endtask

  task automatic t_posting();
    int n;
    xmem_wait <= 8'hFF;
    wr(MEM_PORT_CONFIG_OFS, 16'h0080);
    rd(MEM_PORT_CONFIG_OFS, 16'h0080);
    ext_mem_timeout_enable_i <= 1'b1;
    @(posedge clk_i);
    mem_wr_req_i <= 1'b1;
    mem_wr_addr_i <= 24'h000A10;
    mem_wr_data_i <= 32'h1111AAAA;
    @(posedge clk_i);
    mem_wr_addr_i <= 24'h000B20;
    mem_wr_data_i <= 32'h2222BBBB;
    @(posedge clk_i);
    mem_wr_req_i <= 1'b0;
    #1 chk(mem_wr_stall_o, 1'b1);
    chk({xmem_req_o, xmem_addr_o, xmem_data_o}, {1'b1, 24'h000A10,
        32'h1111AAAA});
    repeat (12) @(posedge clk_i);
    rd(MEM_PORT_ERROR_OFS, 16'h1000);
    ext_mem_timeout_enable_i <= 1'b0;
    xmem_wait <= 8'h00;
    n = 0;
    while (xmem_addr_o !== 24'h000B20 && n < 20)
    begin
      @(posedge clk_i);
      #1 n++;
    end
    chk({xmem_req_o, xmem_data_o}, {1'b1, 32'h2222BBBB});
    repeat (4) @(posedge clk_i);
    #1 chk({xmem_req_o, mem_wr_stall_o}, 2'b00);
    wr(MEM_PORT_CONFIG_OFS, 16'h0000);
    xmem_wait <= 8'h03;
    @(posedge clk_i);
    mem_wr_req_i <= 1'b1;
    @(posedge clk_i);
    mem_wr_req_i <= 1'b0;
    #1 chk(mem_wr_stall_o, 1'b1);
    repeat (8) @(posedge clk_i);
  endtask

  task automatic t_idle();
    per_wait <= 8'hFF;
    periph_idle_request_i <= 1'b1;
    ext_mem_idle_request_i <= 1'b1;
    @(posedge clk_i);
    idle_instr_i <= 1'b1;
    @(posedge clk_i);
    idle_instr_i <= 1'b0;
    #1 chk({idle_bus_error_o, periph_idle_o, mem_idle_o}, 3'b111);
    @(posedge clk_i);
    mem_wr_req_i <= 1'b1;
    per_req_i <= 1'b1;
    per_invalid_i <= 1'b1;
    @(posedge clk_i);
    mem_wr_req_i <= 1'b0;
    per_req_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    #1 chk({mem_wr_stall_o, xmem_req_o}, 2'b10);
    chk({per_stall_o, per_done_o}, 2'b10);
    rd(PERIPH_PORT_ERROR_OFS, 16'h9018);
    @(posedge clk_i);
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    periph_idle_request_i <= 1'b0;
    ext_mem_idle_request_i <= 1'b0;
    xmem_wait <= 8'h00;
    repeat (8) @(posedge clk_i);
    #1 chk({mem_idle_o, xmem_req_o}, 2'b00);
  endtask

  task automatic t_irq();
    rd(IRQ_STATUS_OFS, 16'h000F);
    chk(irq_o, 1'b0);
    wr(IRQ_MASK_OFS, 16'h000F);
    @(posedge clk_i);
    #1 irq_a = irq_o;
    chk(irq_a, 1'b1);
    wr(IRQ_STATUS_OFS, 16'h000F);
    rd(IRQ_STATUS_OFS, 16'h0000);
    chk(irq_o, 1'b0);
    wr(IRQ_MASK_OFS, 16'h0000);
  endtask

  task automatic t_hang();
    wr(PERIPH_PORT_CONFIG_OFS, 16'h0000);
    rd(PERIPH_PORT_CONFIG_OFS, 16'h0000);
    @(posedge clk_i);
    per_req_i <= 1'b1;
    per_addr_i <= 16'h0000;
    per_invalid_i <= 1'b1;
    @(posedge clk_i);
    per_req_i <= 1'b0;
    repeat (30) @(posedge clk_i);
    #1 chk({per_stall_o, per_done_o, per_bus_error_o}, 3'b100);
    rd(PERIPH_PORT_ERROR_OFS, 16'h9018);
    do_reset();
    rd(PERIPH_PORT_CONFIG_OFS, 16'h8000);
    rd(PERIPH_PORT_ERROR_OFS, 16'h0000);
    xmem_other_wait <= 1'b1;
    repeat (12) @(posedge clk_i);
    rd(MEM_PORT_ERROR_OFS, 16'h0000);
    ext_mem_timeout_enable_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rd(MEM_PORT_ERROR_OFS, 16'h1000);
    xmem_other_wait <= 1'b0;
    ext_mem_timeout_enable_i <= 1'b0;
  endtask

  initial
  begin
    do_reset();
    t_reset_values();
    t_periph();
    t_posting();
    t_idle();
    t_irq();
    t_hang();
    final_report();
  end
endmodule
